// >>> verilog/xmp_params.svh
/*
  Constants of the extended management port slave: opcodes, field
  positions, frame lengths and timing.
  Assumes it is included by bare name from every file that needs it.
*/
// What this block does
// - A frame with opcode 10 and address-field bits 2 and 1 both one is an extended read.
// - A frame with opcode 01 and address-field bits 2 and 1 both one is an extended write.
// - The 8-bit index is address-field bits 4, 3, 0 on top of the five register-field bits.
// - In a read turnaround the controller floats the first bit and, on an answered read, the device drives zero on the second.
// - An extended read returns zeros in data bits 15 to 8.
// - An extended write ignores data bits 15 to 8 whatever they hold.
// - Config register contents travel only in the low eight data bits, both ways.
// - Extended frames reach every register index from 0x00 to 0xFF.
// - Standard frames give direct access to management registers 0 to 5, 29 and 31.
// - Frames without the extended selection reach only the standard 16-bit registers.
`ifndef XMP_PARAMS_SVH
`define XMP_PARAMS_SVH

`define XMP_OP_READ 2'h2
`define XMP_OP_WRITE 2'h1
`define XMP_EXT_SEL 2'h3
`define XMP_EXT_SEL_HI 2
`define XMP_EXT_SEL_LO 1
`define XMP_PREAMBLE_ONES 6'h20
`define XMP_HDR_LAST 4'hB
`define XMP_DATA_LAST 4'hF
`define XMP_STD_REG_LAST 5'h05
`define XMP_VEND_REG_A 5'h1D
`define XMP_VEND_REG_B 5'h1F
`define XMP_CLK_PERIOD_NS 10
`define XMP_MDC_MIN_PERIOD_NS 100
`define XMP_MDC_MIN_CYCLES (`XMP_MDC_MIN_PERIOD_NS / `XMP_CLK_PERIOD_NS)

`endif

// >>> verilog/xmp_pkg.sv
/*
  Types of the extended management port slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package xmp_pkg;

  typedef enum logic [2:0] {
    XMP_PRE,
    XMP_START,
    XMP_HDR,
    XMP_TA,
    XMP_DATA
  } xmp_state_t;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] reg_addr_field;
  } xmp_hdr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xmp_cfg_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] phy;
    logic [4:0] reg_addr_field;
    logic [15:0] wdata;
  } xmp_miim_req_t;

endpackage

`default_nettype wire

// >>> verilog/xmp_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none

module xmp_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds the second stage only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // xmp_sync

`default_nettype wire

// >>> verilog/xmp_slave.sv
/*
  Slave end of the extended management port: decodes frames on the
  data pin, serves extended reads and writes to the 8-bit config space
  and standard frames to the 16-bit management registers.
  Assumes the management clock arrives asynchronously, at most 10 MHz,
  and that read data is valid one clk after a read strobe.
*/
`timescale 1ns/1ns
`default_nettype none
`include "xmp_params.svh"

module xmp_slave
  import xmp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // Config register space
  output xmp_cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  // Standard management registers
  output xmp_miim_req_t miim_req,
  input wire logic [15:0] miim_rdata
);

  function automatic logic [7:0] cfg_index(input logic [4:0] phy, input logic [4:0] ra);
    cfg_index = {phy[4:3], phy[0], ra};
  endfunction

  function automatic logic std_reg(input logic [4:0] ra);
    std_reg = (ra <= `XMP_STD_REG_LAST) || (ra == `XMP_VEND_REG_A) ||
              (ra == `XMP_VEND_REG_B);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling; 10 MHz ceiling leaves ten clk per bit for decode

  logic [1:0] pins_s;
  logic mdc_s, mdio_s, mdc_last_q, rise;

  xmp_sync #(.W(2)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({mdc, mdio_i}),
    .q(pins_s)
  );

  assign mdc_s = pins_s[1];
  assign mdio_s = pins_s[0];
  assign rise = mdc_s && !mdc_last_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mdc_last_q <= 1'b0;
    end else begin
      mdc_last_q <= mdc_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  xmp_state_t state_q;
  logic [5:0] ones_q;
  logic [3:0] cnt_q;
  xmp_hdr_t hdr_q;
  logic [15:0] sh_q;
  logic is_rd_q, is_ext_q, answer_q;
  xmp_hdr_t hdr_d;
  logic hdr_ext, hdr_rd, hdr_wr;

  assign hdr_d = {hdr_q[10:0], mdio_s};
  assign hdr_ext = hdr_d.phy[`XMP_EXT_SEL_HI:`XMP_EXT_SEL_LO] == `XMP_EXT_SEL;
  assign hdr_rd = hdr_d.op == `XMP_OP_READ;
  assign hdr_wr = hdr_d.op == `XMP_OP_WRITE;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= XMP_PRE;
      ones_q <= '0;
      cnt_q <= '0;
    end else if (rise) begin
      unique case (state_q)
        XMP_PRE: begin
          if (mdio_s) begin
            if (ones_q != `XMP_PREAMBLE_ONES) begin
              ones_q <= ones_q + 6'h01;
            end
          end else begin
            ones_q <= '0;
            if (ones_q == `XMP_PREAMBLE_ONES) begin
              state_q <= XMP_START;
            end
          end
        end
        XMP_START: begin
          cnt_q <= '0;
          state_q <= mdio_s ? XMP_HDR : XMP_PRE;
        end
        XMP_HDR: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `XMP_HDR_LAST) begin
            cnt_q <= '0;
            state_q <= (hdr_rd || hdr_wr) ? XMP_TA : XMP_PRE;
          end
        end
        XMP_TA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q[0]) begin
            cnt_q <= '0;
            state_q <= XMP_DATA;
          end
        end
        XMP_DATA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `XMP_DATA_LAST) begin
            state_q <= XMP_PRE;
          end
        end
      endcase
    end
  end

  // Header shift and frame classification
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hdr_q <= '0;
      is_rd_q <= 1'b0;
      is_ext_q <= 1'b0;
      answer_q <= 1'b0;
    end else if (rise && state_q == XMP_HDR) begin
      hdr_q <= hdr_d;
      if (cnt_q == `XMP_HDR_LAST) begin
        is_rd_q <= hdr_rd;
        is_ext_q <= hdr_ext;
        answer_q <= hdr_ext || std_reg(hdr_d.reg_addr_field);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register-side strobes

  logic hdr_done, data_done;
  logic [7:0] rdata8_q;
  logic [15:0] rdata16_q;
  logic rd_wait_q;

  assign hdr_done = rise && state_q == XMP_HDR && cnt_q == `XMP_HDR_LAST;
  assign data_done = rise && state_q == XMP_DATA && cnt_q == `XMP_DATA_LAST;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_req <= '0;
      miim_req <= '0;
    end else begin
      cfg_req.rd <= hdr_done && hdr_rd && hdr_ext;
      cfg_req.wr <= data_done && !is_rd_q && is_ext_q;
      miim_req.rd <= hdr_done && hdr_rd && !hdr_ext && std_reg(hdr_d.reg_addr_field);
      miim_req.wr <= data_done && !is_rd_q && !is_ext_q && answer_q;
      if (hdr_done) begin
        cfg_req.addr <= cfg_index(hdr_d.phy, hdr_d.reg_addr_field);
        miim_req.phy <= hdr_d.phy;
        miim_req.reg_addr_field <= hdr_d.reg_addr_field;
      end
      if (data_done) begin
        cfg_req.wdata <= {sh_q[6:0], mdio_s};
        miim_req.wdata <= {sh_q[14:0], mdio_s};
      end
    end
  end

  // Read data is caught one clk after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_wait_q <= 1'b0;
      rdata8_q <= '0;
      rdata16_q <= '0;
    end else begin
      rd_wait_q <= cfg_req.rd || miim_req.rd;
      if (rd_wait_q) begin
        rdata8_q <= cfg_rdata;
        rdata16_q <= miim_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data shifter and pin drive

  logic drive_rd;

  assign drive_rd = is_rd_q && answer_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= '0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (rise) begin
      if (state_q == XMP_TA && !cnt_q[0]) begin
        mdio_oe <= drive_rd;
        mdio_o <= 1'b0;
      end else if (state_q == XMP_TA) begin
        // Extended reads carry the byte in the low half only
        sh_q <= is_ext_q ? {8'h00, rdata8_q} : rdata16_q;
        mdio_o <= is_ext_q ? 1'b0 : rdata16_q[15];
      end else if (state_q == XMP_DATA && drive_rd) begin
        sh_q <= {sh_q[14:0], 1'b0};
        mdio_o <= sh_q[14];
        mdio_oe <= cnt_q != `XMP_DATA_LAST;
      end else if (state_q == XMP_DATA) begin
        sh_q <= {sh_q[14:0], mdio_s};
      end else begin
        mdio_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_ta_first;
    rise && state_q == XMP_TA && !cnt_q[0] && drive_rd;
  endsequence

  sequence s_read_word;
    rise && state_q == XMP_TA && cnt_q[0] && drive_rd && is_ext_q;
  endsequence

  chk_ta_zero_drive: assert property (@(posedge clk) disable iff (!rstn)
    s_ta_first |=> mdio_oe && !mdio_o)
    else $error("device did not drive zero on second turnaround bit");

  chk_upper_byte_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_read_word |=> !mdio_o && sh_q[15:8] == 8'h00)
    else $error("upper byte of extended read not zero");

  chk_read_decode: assert property (@(posedge clk) disable iff (!rstn)
    cfg_req.rd |-> $past(hdr_d.op) == `XMP_OP_READ && is_ext_q && is_rd_q)
    else $error("config read strobe without extended read frame");

  chk_write_decode: assert property (@(posedge clk) disable iff (!rstn)
    cfg_req.wr |-> !is_rd_q && is_ext_q && $past(state_q) == XMP_DATA)
    else $error("config write strobe outside extended write frame");

  chk_index_form: assert property (@(posedge clk) disable iff (!rstn)
    cfg_req.rd |-> cfg_req.addr == {hdr_q.phy[4:3], hdr_q.phy[0], hdr_q.reg_addr_field})
    else $error("config index not built from address fields");

  chk_write_low_byte: assert property (@(posedge clk) disable iff (!rstn)
    cfg_req.wr |-> cfg_req.wdata == miim_req.wdata[7:0])
    else $error("config write data not taken from low byte");

  chk_no_drive_write: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == XMP_TA || state_q == XMP_DATA) && !is_rd_q |-> !mdio_oe)
    else $error("device drove the line during a write frame");

  chk_std_only: assert property (@(posedge clk) disable iff (!rstn)
    miim_req.rd |-> !is_ext_q && std_reg(hdr_q.reg_addr_field))
    else $error("standard access outside standard register set");

  chk_idle_release: assert property (@(posedge clk) disable iff (!rstn)
    data_done |=> !mdio_oe [*2])
    else $error("line not released after data field");

endmodule // xmp_slave

`default_nettype wire

// >>> verification/xmp_ctl_model.sv
/*
  Model of the management controller: makes the management clock and
  sends frames bit by bit, sampling read bits just before each rise.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module xmp_ctl_model import xmp_pkg::*; (
  // Pins
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe
);
  initial begin
    mdc = 1'b0;
    mdio_o = 1'b0;
    mdio_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // One bit: change while low, 125 ns period keeps under the limit
  task automatic bit_cyc(input logic oe, input logic v, output logic s);
    mdc = 1'b0;
    mdio_oe = oe;
    mdio_o = v;
    #62;
    s = mdio_in;
    mdc = 1'b1;
    #63;
  endtask

  // Whole frame; on a read the turnaround and data are left to the device
  task automatic frame(input int npre, input xmp_hdr_t h, input logic [15:0] wd,
                       output logic [17:0] rx);
    logic [13:0] hb;
    logic [17:0] tx;
    logic rd;
    logic b;
    hb = {2'b01, h};
    tx = {2'b10, wd};
    rd = (h.op == 2'b10);
    for (int i = 0; i < npre; i++) bit_cyc(1'b1, 1'b1, b);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hb[i], b);
    for (int i = 17; i >= 0; i--) begin
      bit_cyc(!rd, tx[i], b);
      rx[i] = b;
    end
    // Clock stands still between frames, line released
    mdc = 1'b0;
    mdio_oe = 1'b0;
  endtask
endmodule // xmp_ctl_model

`default_nettype wire

// >>> verification/test_smi_register_access_slave.sv
/*
  Self-checking bench of the extended management port slave.
  Assumes the controller model file and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_smi_register_access_slave;
  import xmp_pkg::*;
  logic clk, rstn, mdc, mdio_i, mdio_o, mdio_oe, c_o, c_oe, ok;
  xmp_cfg_req_t cfg_req, last_c;
  xmp_miim_req_t miim_req, last_m;
  logic [7:0] cfg_rdata, a;
  logic [15:0] miim_rdata, d;
  logic [17:0] rx;
  logic [63:0] bad;
  logic [4:0] p;
  logic [7:0] mem [256];
  logic [15:0] mm [1024];
  logic [4:0] sr [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1D, 5'h1F, 5'h06, 5'h1E};
  int failures, n_checks, cyc, n_crd, n_cwr, n_mrd, n_mwr, c0, m0;

  // Pull-up when nobody drives
  assign mdio_i = mdio_oe ? mdio_o : (c_oe ? c_o : 1'b1);

  xmp_slave i_dut (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .miim_req(miim_req),
    .miim_rdata(miim_rdata));
  xmp_ctl_model i_ctl (.mdio_in(mdio_i), .mdc(mdc), .mdio_o(c_o), .mdio_oe(c_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  // Register side: data valid the clk after a read strobe
  always @(negedge clk) begin
    cfg_rdata <= mem[cfg_req.addr];
    miim_rdata <= mm[{miim_req.phy, miim_req.reg_addr_field}];
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      failures++;
      end_of_test();
    end
    if (cfg_req.rd) n_crd++;
    if (miim_req.rd) n_mrd++;
    if (cfg_req.wr) begin
      n_cwr++;
      last_c <= cfg_req;
      mem[cfg_req.addr] <= cfg_req.wdata;
    end
    if (miim_req.wr) begin
      n_mwr++;
      last_m <= miim_req;
      mm[{miim_req.phy, miim_req.reg_addr_field}] <= miim_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic xmp_hdr_t ext_h(input logic [1:0] op, input logic [7:0] ad);
    return {op, ad[7:6], 2'b11, ad[5], ad[4:0]};
  endfunction

  // Strobes land a few clks after the last bit
  task automatic run(input int npre, input xmp_hdr_t h, input logic [15:0] wd);
    i_ctl.frame(npre, h, wd, rx);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic int sum_req();
    return n_cwr + n_crd + n_mwr + n_mrd;
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    cfg_rdata = 8'h00;
    miim_rdata = 16'h0000;
    void'($urandom(89));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    for (int i = 0; i < 1024; i++) mm[i] = 16'($urandom);
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (4) @(negedge clk);
    // Extended write then read back, both ends of the index space first
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : 8'($urandom));
      d = 16'($urandom);
      c0 = n_cwr;
      run(32, ext_h(2'b01, a), d);
      chk("wr_count", c0 + 1, n_cwr);
      chk("wr_addr", a, last_c.addr);
      chk("wr_data", d[7:0], last_c.wdata);
      c0 = n_crd;
      run(32, ext_h(2'b10, a), 16'h0000);
      chk("rd_count", c0 + 1, n_crd);
      chk("rd_frame", {2'b10, 8'h00, d[7:0]}, rx);
      chk("idle_oe", 1'b0, mdio_oe);
    end
    // Standard frames: listed registers on the 16-bit port, others unanswered
    for (int j = 0; j < 10; j++) begin
      p = 5'($urandom) & 5'h19;
      ok = (j < 8);
      d = 16'($urandom);
      c0 = n_cwr + n_crd;
      m0 = n_mwr;
      run(32, {2'b01, p, sr[j]}, d);
      chk("std_wr", m0 + (ok ? 1 : 0), n_mwr);
      if (ok) chk("std_wdata", d, last_m.wdata);
      if (ok) chk("std_addr", {p, sr[j]}, {last_m.phy, last_m.reg_addr_field});
      m0 = n_mrd;
      run(32, {2'b10, p, sr[j]}, 16'h0000);
      chk("std_rd_count", m0 + (ok ? 1 : 0), n_mrd);
      chk("std_rd", ok ? {2'b10, d} : 18'h3_FFFF, rx);
      chk("no_cfg", c0, n_cwr + n_crd);
    end
    // Short preamble and reserved opcodes are dropped, then a good frame
    c0 = sum_req();
    run(31, ext_h(2'b01, 8'h5A), 16'h00A5);
    run(32, ext_h(2'b00, 8'h5A), 16'h00A5);
    run(32, ext_h(2'b11, 8'h5A), 16'h00A5);
    // Start pattern 00 after a full preamble must not open a frame
    bad = {32'hFFFF_FFFF, 2'b00, ext_h(2'b01, 8'h5A), 2'b10, 16'h00A5};
    for (int i = 63; i >= 0; i--) i_ctl.bit_cyc(1'b1, bad[i], ok);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("dropped", c0, sum_req());
    run(32, ext_h(2'b01, 8'hA5), 16'hFF3C);
    chk("recover", c0 + 1, sum_req());
    chk("recover_data", 8'h3C, last_c.wdata);
    end_of_test();
  end
endmodule // test_smi_register_access_slave

`default_nettype wire
